/* File: ecc_ram_defines.vh */
// Purpose: shared constants for the on-chip RAM controller
// Assumes: 32-bit register bus, byte addresses
// Notes:   definitions only
`ifndef ECC_RAM_DEFINES_VH
`define ECC_RAM_DEFINES_VH

// register byte offsets
`define REG_CTRL           32'h00000000
`define REG_INT_STATUS     32'h00000004
`define REG_INT_MASK       32'h00000008
`define REG_NMI_SEL        32'h0000000C
`define REG_PLAIN_ERR_ADDR 32'h00000010
`define REG_SGL_ERR_ADDR   32'h00000014
`define REG_DBL_ERR_ADDR   32'h00000018

// control fields
`define CTRL_PLAIN_EN   0
`define CTRL_ECC_EN     1
`define CTRL_MEM_WAIT   2
`define CTRL_PLAIN_STOP 3
`define CTRL_ECC_STOP   4
`define CTRL_SGL_UPD_EN 5
`define CTRL_RESET      6'h01

// interrupt status fields
`define INT_PLAIN_PAR 0
`define INT_ECC_SGL   1
`define INT_ECC_DBL   2
`define INT_RESET     3'h0

// address map
`define PLAIN_END_ADDR 32'h0001FFFF
`define ECC_BASE_ADDR  32'h00FFC000
`define ECC_END_ADDR   32'h00FFFFFF

// access lengths in clock cycles
`define LAT_W0      3'h2
`define LAT_W0_ERR  3'h3
`define LAT_W1      3'h3
`define LAT_W1_WR   3'h4
`define LAT_W1_ERR  3'h5

// axi responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: word_ram.v */
// Purpose: word-wide storage array, write on clock, read without clock
// Assumes: one write port, one read port sharing the address
// Notes:   caller registers read data where a flop is needed
`timescale 1ns/1ps
module word_ram #(
  parameter DW = 32,
  parameter AW = 10
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output wire [DW-1:0] q
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // storage write
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign q = mem[addr];
endmodule // word_ram

/* File: secded_codec.v */
// Purpose: single-correct double-detect code for 32-bit words
// Assumes: code word {overall, check[5:0], data[31:0]}
// Notes:   purely combinational
`timescale 1ns/1ps
module secded_codec (
  input  wire [31:0] enc_data,
  output reg  [6:0]  enc_chk,
  input  wire [38:0] code_word,
  output reg  [31:0] cor_data,
  output reg         sgl_err,
  output reg         dbl_err
);
  integer    pe, ie, je, pd, id, jd;
  reg [5:0]  syn;
  reg        ovr;

  // check bits: data sits at the non-power-of-two positions 3..38
  always @* begin
    enc_chk = 7'h00;
    je = 0;
    for (pe = 1; pe < 39; pe = pe + 1) begin
      if ((pe & (pe - 1)) != 0) begin
        for (ie = 0; ie < 6; ie = ie + 1) begin
          if (((pe >> ie) & 1) == 1) enc_chk[ie] = enc_chk[ie] ^ enc_data[je];
        end
        je = je + 1;
      end
    end
    enc_chk[6] = ^{enc_data, enc_chk[5:0]};
  end

  // syndrome, classification and correction
  always @* begin
    syn = code_word[37:32];
    jd  = 0;
    for (pd = 1; pd < 39; pd = pd + 1) begin
      if ((pd & (pd - 1)) != 0) begin
        for (id = 0; id < 6; id = id + 1) begin
          if (((pd >> id) & 1) == 1) syn[id] = syn[id] ^ code_word[jd];
        end
        jd = jd + 1;
      end
    end
    ovr      = ^code_word;
    sgl_err  = ovr;                       // odd flips: correctable
    dbl_err  = ~ovr & (syn != 6'h00);     // even flips: detect only
    cor_data = code_word[31:0];
    jd = 0;
    for (pd = 1; pd < 39; pd = pd + 1) begin
      if ((pd & (pd - 1)) != 0) begin
        if (ovr && (syn == pd)) cor_data[jd] = ~code_word[jd];
        jd = jd + 1;
      end
    end
  end
endmodule // secded_codec

/* File: ecc_onchip_ram_controller.v */
// Purpose: on-chip RAM access logic, plain parity RAM plus ECC region
// Assumes: one clock, memory bus strobes from same-clock logic
// Notes:   registers over AXI4-Lite, one access in flight on the memory bus
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ecc_ram_defines.vh"
module ecc_onchip_ram_controller (
  input  wire        CORE_CLK,
  input  wire        ARST_N,
  input  wire        AWVALID,
  output reg         AWREADY,
  input  wire [31:0] AWADDR,
  input  wire        WVALID,
  output reg         WREADY,
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  output reg         BVALID,
  input  wire        BREADY,
  output reg  [1:0]  BRESP,
  input  wire        ARVALID,
  output reg         ARREADY,
  input  wire [31:0] ARADDR,
  output reg         RVALID,
  input  wire        RREADY,
  output reg  [31:0] RDATA,
  output reg  [1:0]  RRESP,
  input  wire        MEM_REQ,
  input  wire        MEM_WE,
  input  wire [3:0]  MEM_BE,
  input  wire [31:0] MEM_ADDR,
  input  wire [31:0] MEM_WDATA,
  output reg         MEM_ACK,
  output reg  [31:0] MEM_RDATA,
  output reg         MEM_ERR,
  output reg         IRQ,
  output reg         NMI
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ECC  = 2'b10;

  reg         rst_meta_ff;
  reg         rst_sync_ff;
  reg  [5:0]  ctrl_ff;
  reg  [2:0]  status_ff;
  reg  [2:0]  mask_ff;
  reg  [2:0]  nmisel_ff;
  reg  [31:0] cap_plain_ff;
  reg  [31:0] cap_sgl_ff;
  reg  [31:0] cap_dbl_ff;
  reg  [1:0]  state_ff;
  reg         lwe_ff;
  reg  [3:0]  lbe_ff;
  reg  [31:0] laddr_ff;
  reg  [31:0] lwdata_ff;
  reg  [38:0] rdw_ff;
  reg  [2:0]  cnt_ff;
  reg         aw_have_ff;
  reg         w_have_ff;
  reg  [31:0] awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg  [2:0]  lat;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  reg  [2:0]  nxt_status;
  wire        rst_n;
  wire [32:0] plain_q;
  wire [38:0] ecc_q;
  wire [6:0]  enc_chk;
  wire [31:0] cor_data;
  wire        sgl_err;
  wire        dbl_err;

  // byte-lane merge of new data over an old word
  function [31:0] merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  be;
    integer      b;
    begin
      merge = old_w;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) merge[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  //////////////////////////////////////////////////////////////////////////////
  // address decode and gating
  wire idle       = state_ff[0];
  wire plain_hit  = (MEM_ADDR <= `PLAIN_END_ADDR);
  wire ecc_hit    = (MEM_ADDR >= `ECC_BASE_ADDR) && (MEM_ADDR <= `ECC_END_ADDR);
  wire plain_ok   = plain_hit & ctrl_ff[`CTRL_PLAIN_EN] & ~ctrl_ff[`CTRL_PLAIN_STOP];
  wire ecc_ok     = ecc_hit & ~ctrl_ff[`CTRL_ECC_STOP];
  wire take       = MEM_REQ & idle;
  wire ecc_en     = ctrl_ff[`CTRL_ECC_EN];
  wire mem_wait   = ctrl_ff[`CTRL_MEM_WAIT];

  // plain RAM: parity bit in bit 32, written in the accept cycle
  wire [31:0] plain_merged = merge(plain_q[31:0], MEM_WDATA, MEM_BE);
  wire        plain_we     = take & plain_ok & MEM_WE;
  wire        plain_bad    = plain_q[32] ^ (^plain_q[31:0]);

  word_ram #(.DW(33), .AW(15)) u_plain_ram (
    .clk   (CORE_CLK),
    .we    (plain_we),
    .addr  (MEM_ADDR[16:2]),
    .wdata ({^plain_merged, plain_merged}),
    .q     (plain_q)
  );

  // ECC region: old word read at accept, merged word written at the end
  wire        partial    = (lbe_ff != 4'hF);
  wire [31:0] old_word   = ecc_en ? cor_data : rdw_ff[31:0];
  wire [31:0] ecc_merged = merge(old_word, lwdata_ff, lbe_ff);
  wire        ecc_err    = ecc_en & (sgl_err | dbl_err) & (~lwe_ff | partial);
  wire [2:0]  nxt_cnt    = cnt_ff + 3'h1;
  wire        done       = state_ff[1] & (nxt_cnt == lat);
  wire [11:0] ecc_idx    = idle ? MEM_ADDR[13:2] : laddr_ff[13:2];
  wire [6:0]  store_chk  = ecc_en ? enc_chk : 7'h00;

  word_ram #(.DW(39), .AW(12)) u_ecc_ram (
    .clk   (CORE_CLK),
    .we    (done & lwe_ff),
    .addr  (ecc_idx),
    .wdata ({store_chk, ecc_merged}),
    .q     (ecc_q)
  );

  secded_codec u_codec (
    .enc_data  (ecc_merged),
    .enc_chk   (enc_chk),
    .code_word (rdw_ff),
    .cor_data  (cor_data),
    .sgl_err   (sgl_err),
    .dbl_err   (dbl_err)
  );

  // error events; a full-word write replaces the word so it cannot fail
  wire ev_par = take & plain_ok & ~MEM_WE & ctrl_ff[`CTRL_PLAIN_EN] & plain_bad;
  wire ev_sgl = done & ecc_err & sgl_err & ctrl_ff[`CTRL_SGL_UPD_EN];
  wire ev_dbl = done & ecc_err & dbl_err;

  //////////////////////////////////////////////////////////////////////////////
  // access length by wait setting, ECC mode, error and direction
  always @* begin
    if (!mem_wait) begin
      lat = ecc_err ? `LAT_W0_ERR : `LAT_W0;
    end else if (!ecc_en) begin
      lat = `LAT_W1;
    end else if (ecc_err) begin
      lat = `LAT_W1_ERR;
    end else begin
      lat = lwe_ff ? `LAT_W1_WR : `LAT_W1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // memory bus sequencer; the accept edge counts as cycle one
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= ST_IDLE;
      MEM_ACK   <= 1'b0;
      MEM_ERR   <= 1'b0;
      MEM_RDATA <= 32'h00000000;
      lwe_ff    <= 1'b0;
      lbe_ff    <= 4'h0;
      laddr_ff  <= 32'h00000000;
      lwdata_ff <= 32'h00000000;
      rdw_ff    <= 39'h0000000000;
      cnt_ff    <= 3'h0;
    end else begin
      MEM_ACK <= 1'b0;
      MEM_ERR <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (MEM_REQ) begin
            if (plain_ok) begin
              MEM_ACK   <= 1'b1;
              MEM_ERR   <= ev_par;
              MEM_RDATA <= MEM_WE ? 32'h00000000 : plain_q[31:0];
            end else if (ecc_ok) begin
              lwe_ff    <= MEM_WE;
              lbe_ff    <= MEM_BE;
              laddr_ff  <= MEM_ADDR;
              lwdata_ff <= MEM_WDATA;
              rdw_ff    <= ecc_q;
              cnt_ff    <= 3'h1;
              state_ff  <= ST_ECC;
            end else begin
              // unmapped, disabled or stopped: refused at once
              MEM_ACK   <= 1'b1;
              MEM_ERR   <= 1'b1;
              MEM_RDATA <= 32'h00000000;
            end
          end
        end
        ST_ECC: begin
          cnt_ff <= nxt_cnt;
          if (done) begin
            MEM_ACK   <= 1'b1;
            MEM_ERR   <= ecc_err & dbl_err;
            MEM_RDATA <= lwe_ff ? 32'h00000000 : old_word;
            state_ff  <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register bus handshakes
  wire aw_hs   = AWVALID & AWREADY;
  wire w_hs    = WVALID & WREADY;
  wire ar_hs   = ARVALID & ARREADY;
  wire wr_go   = aw_have_ff & w_have_ff & ~BVALID;
  wire st_clr  = ar_hs & (ARADDR == `REG_INT_STATUS);
  wire wr_ctrl = wr_go & (awaddr_ff == `REG_CTRL) & wstrb_ff[0];
  wire wr_mask = wr_go & (awaddr_ff == `REG_INT_MASK) & wstrb_ff[0];
  wire wr_nmi  = wr_go & (awaddr_ff == `REG_NMI_SEL) & wstrb_ff[0];
  wire wr_hit  = (awaddr_ff == `REG_CTRL) || (awaddr_ff == `REG_INT_MASK) || (awaddr_ff == `REG_NMI_SEL);

  // read decode; status is read-to-clear
  always @* begin
    rd_hit = 1'b1;
    case (ARADDR)
      `REG_CTRL:           rd_mux = {26'h0, ctrl_ff};
      `REG_INT_STATUS:     rd_mux = {29'h0, status_ff};
      `REG_INT_MASK:       rd_mux = {29'h0, mask_ff};
      `REG_NMI_SEL:        rd_mux = {29'h0, nmisel_ff};
      `REG_PLAIN_ERR_ADDR: rd_mux = cap_plain_ff;
      `REG_SGL_ERR_ADDR:   rd_mux = cap_sgl_ff;
      `REG_DBL_ERR_ADDR:   rd_mux = cap_dbl_ff;
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // write address, write data and response channels
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      AWREADY    <= 1'b1;
      WREADY     <= 1'b1;
      BVALID     <= 1'b0;
      BRESP      <= `RESP_OKAY;
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= 32'h00000000;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_ff  <= AWADDR;
        aw_have_ff <= 1'b1;
        AWREADY    <= 1'b0;
      end
      if (w_hs) begin
        wdata_ff  <= WDATA;
        wstrb_ff  <= WSTRB;
        w_have_ff <= 1'b1;
        WREADY    <= 1'b0;
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (BVALID & BREADY) begin
        BVALID     <= 1'b0;
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        AWREADY    <= 1'b1;
        WREADY     <= 1'b1;
      end
    end
  end

  // read address and read data channels
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= `RESP_OKAY;
    end else begin
      if (ar_hs) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RDATA   <= rd_mux;
        RRESP   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (RVALID & RREADY) begin
        RVALID  <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status: an event in the clearing cycle wins over the clear
  always @* begin
    nxt_status = status_ff & ~{3{st_clr}};
    nxt_status = nxt_status | {ev_dbl, ev_sgl, ev_par};
  end

  // control, capture and interrupt registers
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff      <= `CTRL_RESET;
      status_ff    <= `INT_RESET;
      mask_ff      <= 3'h0;
      nmisel_ff    <= 3'h0;
      cap_plain_ff <= 32'h00000000;
      cap_sgl_ff   <= 32'h00000000;
      cap_dbl_ff   <= 32'h00000000;
      IRQ          <= 1'b0;
      NMI          <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_ff <= wdata_ff[5:0];
      if (wr_mask) mask_ff <= wdata_ff[2:0];
      if (wr_nmi) nmisel_ff <= wdata_ff[2:0];
      status_ff <= nxt_status;
      if (ev_par) cap_plain_ff <= MEM_ADDR;
      if (ev_sgl) cap_sgl_ff <= laddr_ff;
      if (ev_dbl) cap_dbl_ff <= laddr_ff;
      // non-maskable route ignores the mask by design
      NMI <= |(nxt_status & nmisel_ff);
      IRQ <= |(nxt_status & mask_ff & ~nmisel_ff);
    end
  end
endmodule // ecc_onchip_ram_controller

/* File: ecc_ram_monitor.sv */
// Purpose: port checker for the on-chip RAM controller
// Assumes: one clock, ARST_N active low
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/1ps
`include "ecc_ram_defines.vh"
module ecc_ram_monitor (
  input wire        CORE_CLK,
  input wire        ARST_N,
  input wire        AWREADY,
  input wire        WREADY,
  input wire        BVALID,
  input wire        ARVALID,
  input wire        ARREADY,
  input wire        RVALID,
  input wire        RREADY,
  input wire        MEM_REQ,
  input wire [31:0] MEM_ADDR,
  input wire        MEM_ACK,
  input wire [31:0] MEM_RDATA,
  input wire        MEM_ERR,
  input wire        NMI
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////////////////////////////////////////////
  wire plain_req = MEM_REQ && (MEM_ADDR <= `PLAIN_END_ADDR);
  wire ecc_req   = MEM_REQ && (MEM_ADDR >= `ECC_BASE_ADDR) && (MEM_ADDR <= `ECC_END_ADDR);
  reg  busy_ff;
  // ecc access in flight; strobes then are ignored, so antecedents skip them
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) busy_ff <= 1'h0;
    else if (ecc_req && !busy_ff) busy_ff <= 1'h1;
    else if (MEM_ACK) busy_ff <= 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ecc_take; ecc_req && !busy_ff; endsequence
  sequence s_ecc_wait; !MEM_ACK ##[1:4] MEM_ACK; endsequence
  property p_plain_one; plain_req && !busy_ff |=> MEM_ACK; endproperty
  property p_ecc_len; s_ecc_take |=> (MEM_ACK && MEM_ERR) or s_ecc_wait; endproperty
  property p_err_ack; MEM_ERR |-> MEM_ACK; endproperty
  property p_rdata_hold; !MEM_ACK |-> $stable(MEM_RDATA); endproperty
  property p_nmi_cause; $rose(NMI) |-> MEM_ACK; endproperty
  property p_b_ready; BVALID |-> !AWREADY && !WREADY; endproperty
  property p_r_lat; ARVALID && ARREADY |=> RVALID && !ARREADY; endproperty
  property p_r_done; RVALID && RREADY |=> !RVALID && ARREADY; endproperty
  a_plain_one:
    assert property (p_plain_one) else $error("plain access not answered next cycle");
  a_ecc_len:
    assert property (p_ecc_len) else $error("ecc access answered outside two to five cycles");
  a_err_ack:
    assert property (p_err_ack) else $error("error flag without acknowledge");
  a_rdata_hold:
    assert property (p_rdata_hold) else $error("read data moved without acknowledge");
  a_nmi_cause:
    assert property (p_nmi_cause) else $error("nmi raised without a memory access");
  a_b_ready:
    assert property (p_b_ready) else $error("write channel ready while response pending");
  a_r_lat:
    assert property (p_r_lat) else $error("read data not valid one cycle after address");
  a_r_done:
    assert property (p_r_done) else $error("read valid held after handshake");
endmodule // ecc_ram_monitor

bind ecc_onchip_ram_controller ecc_ram_monitor i_ecc_ram_monitor (.*);

/* File: mem_master.sv */
// Purpose: memory bus master standing in for the cpu side
// Assumes: one-cycle strobe, waits for acknowledge however long
// Notes:   byte lanes set by the bench, full word by default; lines turn to inverse when released
`timescale 1ns/1ps
module mem_master (
  input  wire        clk,
  output reg         req   = 1'h0,
  output reg         we    = 1'h0,
  output reg  [3:0]  be    = 4'hF,
  output reg  [31:0] addr  = 32'h0,
  output reg  [31:0] wdata = 32'h0,
  input  wire        ack,
  input  wire [31:0] rdata,
  input  wire        err
);
  // lanes for the next access; partial writes exercise the read-merge-write path
  logic [3:0] lanes = 4'hF;
  ////////////////////////////////////////////////////////////////////////////////
  // one access; n counts edges from take to acknowledge, take edge is 1
  task automatic access(input logic w, input logic [31:0] a, d, output logic [31:0] q,
                        output logic e, output int n);
    @(posedge clk);
    req <= 1'h1;
    we <= w;
    be <= lanes;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'h0;
    we <= ~w;
    be <= ~lanes;
    addr <= ~a;
    wdata <= ~d;
    n = 1;
    forever begin
      @(posedge clk);
      if (ack) break;
      n++;
    end
    q = rdata;
    e = err;
  endtask
endmodule // mem_master

/* File: tb.sv */
// Purpose: self-checking bench for the on-chip RAM controller
// Assumes: 20 MHz clock, axi4-lite register access
// Notes:   ecc errors made by writing with ecc off, reading with it on
`timescale 1ns/1ps
`include "ecc_ram_defines.vh"
module tb;
  reg         CORE_CLK = 1'h0;
  reg         ARST_N = 1'h0;
  reg         AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  reg  [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0;
  reg  [3:0]  WSTRB = 4'hF;
  wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, MEM_REQ, MEM_WE, MEM_ACK, MEM_ERR, IRQ, NMI;
  wire [1:0]  BRESP, RRESP;
  wire [3:0]  MEM_BE;
  wire [31:0] RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  int         n_mismatch = 0, n_checks = 0;
  localparam  B = `ECC_BASE_ADDR;
  ecc_onchip_ram_controller i_ecc_onchip_ram_controller (.*);
  mem_master i_mem_master (.clk(CORE_CLK), .req(MEM_REQ), .we(MEM_WE), .be(MEM_BE), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA), .err(MEM_ERR));
  // free-running clock, 50 ns period
  always #25 CORE_CLK = ~CORE_CLK;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // both channels offered together, each dropped when taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    logic aw_go;
    logic w_go;
    aw_go = 1'b1;
    w_go = 1'b1;
    @(posedge CORE_CLK);
    AWVALID <= 1'h1;
    AWADDR <= a;
    WVALID <= 1'h1;
    WDATA <= d;
    BREADY <= 1'h1;
    // each channel released at the edge where its ready is sampled high
    do begin
      @(posedge CORE_CLK);
      if (aw_go && AWREADY) begin
        AWVALID <= 1'h0;
        aw_go = 1'b0;
      end
      if (w_go && WREADY) begin
        WVALID <= 1'h0;
        w_go = 1'b0;
      end
    end while (aw_go || w_go);
    while (!BVALID) @(posedge CORE_CLK);
    BREADY <= 1'h0;
    cmp(BRESP, r);
  endtask
  task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
    @(posedge CORE_CLK);
    ARVALID <= 1'h1;
    ARADDR <= a;
    do @(posedge CORE_CLK); while (!ARREADY);
    ARVALID <= 1'h0;
    RREADY <= 1'h1;
    do @(posedge CORE_CLK); while (!RVALID);
    RREADY <= 1'h0;
    cmp(RDATA, d);
    cmp(RRESP, r);
  endtask
  // data is only defined when no error is expected
  task automatic mem(input logic w, input logic [31:0] a, d, q, input logic e, input int n);
    logic [31:0] got_q;
    logic        got_e;
    int          got_n;
    i_mem_master.access(w, a, d, got_q, got_e, got_n);
    if (!e) cmp(got_q, q);
    cmp(got_e, e);
    cmp(got_n, n);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge CORE_CLK);
    ARST_N <= 1'h1;
    repeat (3) @(posedge CORE_CLK);
    rd(`REG_CTRL, 32'h1, `RESP_OKAY);
    rd(`REG_INT_STATUS, 32'h0, `RESP_OKAY);
    rd(32'h1C, 32'h0, `RESP_SLVERR);
    wr(`REG_INT_STATUS, 32'h1, `RESP_SLVERR);
    mem(1'h1, 32'h100, 32'hA5A55A5A, 32'h0, 1'h0, 1);
    mem(1'h0, 32'h100, 32'h0, 32'hA5A55A5A, 1'h0, 1);
    mem(1'h1, 32'h1FFFC, 32'h1234, 32'h0, 1'h0, 1);
    mem(1'h0, 32'h1FFFC, 32'h0, 32'h1234, 1'h0, 1);
    mem(1'h0, 32'h20000, 32'h0, 32'h0, 1'h1, 1);
    wr(`REG_CTRL, 32'h0, `RESP_OKAY);
    mem(1'h0, 32'h100, 32'h0, 32'h0, 1'h1, 1);
    wr(`REG_CTRL, 32'h9, `RESP_OKAY);
    mem(1'h0, 32'h100, 32'h0, 32'h0, 1'h1, 1);
    mem(1'h1, B, 32'h5, 32'h0, 1'h0, 2);
    wr(`REG_CTRL, 32'h11, `RESP_OKAY);
    mem(1'h0, B, 32'h0, 32'h0, 1'h1, 1);
    mem(1'h0, 32'h100, 32'h0, 32'hA5A55A5A, 1'h0, 1);
    // every wait and ecc setting: write, then read back at the region top
    for (int i = 0; i < 4; i++) begin
      wr(`REG_CTRL, 32'h21 | (i << 1), `RESP_OKAY);
      mem(1'h1, `ECC_END_ADDR - 3, 32'h70 + i, 32'h0, 1'h0, i < 2 ? 2 : (i == 3 ? 4 : 3));
      mem(1'h0, `ECC_END_ADDR - 3, 32'h0, 32'h70 + i, 1'h0, i < 2 ? 2 : 3);
    end
    // two check bits off: uncorrectable, maskable interrupt
    wr(`REG_INT_MASK, 32'h6, `RESP_OKAY);
    wr(`REG_CTRL, 32'h21, `RESP_OKAY);
    mem(1'h1, B + 8, 32'h3, 32'h0, 1'h0, 2);
    wr(`REG_CTRL, 32'h23, `RESP_OKAY);
    mem(1'h0, B + 8, 32'h0, 32'h0, 1'h1, 3);
    cmp(IRQ, 1'h1);
    rd(`REG_DBL_ERR_ADDR, B + 8, `RESP_OKAY);
    rd(`REG_INT_STATUS, 32'h4, `RESP_OKAY);
    rd(`REG_INT_STATUS, 32'h0, `RESP_OKAY);
    cmp(IRQ, 1'h0);
    // only the overall parity bit off: correctable, update gated
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    mem(1'h1, B + 12, 32'h7, 32'h0, 1'h0, 2);
    wr(`REG_CTRL, 32'h3, `RESP_OKAY);
    mem(1'h0, B + 12, 32'h0, 32'h7, 1'h0, 3);
    rd(`REG_INT_STATUS, 32'h0, `RESP_OKAY);
    wr(`REG_NMI_SEL, 32'h2, `RESP_OKAY);
    wr(`REG_CTRL, 32'h27, `RESP_OKAY);
    mem(1'h0, B + 12, 32'h0, 32'h7, 1'h0, 5);
    cmp(NMI, 1'h1);
    cmp(IRQ, 1'h0);
    rd(`REG_SGL_ERR_ADDR, B + 12, `RESP_OKAY);
    rd(`REG_INT_STATUS, 32'h2, `RESP_OKAY);
    // partial write over the single-error word: corrected old word merged, error length
    i_mem_master.lanes = 4'h1;
    mem(1'h1, B + 12, 32'hAA, 32'h0, 1'h0, 5);
    i_mem_master.lanes = 4'hF;
    mem(1'h0, B + 12, 32'h0, 32'hAA, 1'h0, 3);
    print_verdict;
  end
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
endmodule // tb
